//--- common/drive_timing_defines.vh
/*
 Timing register map, field positions, reset values and fixed eight-bit
 cycle counts for the drive cycle timing encoder.
 Assumes inclusion by bare name from the design files.
*/
`ifndef DRIVE_TIMING_DEFINES_VH
`define DRIVE_TIMING_DEFINES_VH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define SEC_READ_TIMING_ADDR   10'h170
`define SEC_WRITE_TIMING_ADDR  10'h171
`define SEC_MISC_CONTROL_ADDR  10'h176
`define PRI_READ_TIMING_ADDR   10'h1f0
`define PRI_WRITE_TIMING_ADDR  10'h1f1
`define PRI_MISC_CONTROL_ADDR  10'h1f6

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define PULSE_MSB      7
`define PULSE_LSB      4
`define RECOV_MSB      3
`define RECOV_LSB      0
`define RDLY_MSB       3
`define RDLY_LSB       1
`define SET_SEL_BIT    0

// ---------------------------------------------------------------
// Reset values and decode offsets
// ---------------------------------------------------------------
`define TIMING_RESET   8'h00
`define MISC_RESET     8'h00
`define PULSE_BIAS     5'h01
`define RECOV_BIAS     5'h02
`define RDLY_BIAS      5'h02

// ---------------------------------------------------------------
// Fixed eight-bit cycle counts, in clocks
// ---------------------------------------------------------------
`define BYTE_PULSE     5'h0a
`define BYTE_RECOV     5'h09
`define BYTE_RDLY      5'h04

`endif

//--- logic/drive_cycle_timing_encoder.v
/*
 Drive cycle timing encoder: holds the per-channel timing registers in two
 sets, decodes them into clock counts and sequences the drive strobes.
 Assumes a host-side target that presents decoded byte-wide I/O accesses
 as one-cycle pulses on core_clk_i, and a drive ready pin from off chip.
*/
`timescale 1ns/10ps
`default_nettype none
`include "drive_timing_defines.vh"

module drive_cycle_timing_encoder (
   input  wire       core_clk_i,
   input  wire       rst_n_i,
   input  wire       reg_access_i,     // One-cycle I/O access pulse
   input  wire       reg_write_i,      // 1 write, 0 read
   input  wire [9:0] reg_addr_i,
   input  wire [7:0] reg_wdata_i,
   input  wire       cycle_start_i,    // One-cycle drive cycle request
   input  wire       cycle_write_i,
   input  wire       cycle_chan_i,     // 0 primary, 1 secondary
   input  wire       cycle_byte_i,     // Eight-bit drive cycle
   input  wire       drive_io_ready_n_i, // Drive ready pin, high when ready
   output reg  [7:0] reg_rdata_o,
   output reg        prog_mode_o,
   output reg        drive_read_strobe_n_o,
   output reg        drive_write_strobe_n_o,
   output reg        cycle_busy_o,
   output reg        cycle_done_o
);

   // ------------------------------------------------------------
   // Reset release and pin synchroniser
   // ------------------------------------------------------------
   reg rst_s1_reg, rst_s2_reg;
   reg rdy_s1_reg, rdy_s2_reg;
   wire rst_n = rst_s2_reg;

   // Reset release through two flops
   always @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_s1_reg <= 1'b0;
         rst_s2_reg <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_s2_reg <= rst_s1_reg;
      end
   end

   // Ready pin synchroniser
   always @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         rdy_s1_reg <= 1'b0;
         rdy_s2_reg <= 1'b0;
      end else begin
         rdy_s1_reg <= drive_io_ready_n_i;
         rdy_s2_reg <= rdy_s1_reg;
      end
   end

   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   // Index: {channel, set}
   reg [7:0] read_timing_reg  [0:3];
   reg [7:0] write_timing_reg [0:3];
   reg [7:0] misc_reg         [0:1];
   reg       last_wt_read_reg;

   wire hit_pri_rd = (reg_addr_i == `PRI_READ_TIMING_ADDR);
   wire hit_sec_rd = (reg_addr_i == `SEC_READ_TIMING_ADDR);
   wire hit_pri_wt = (reg_addr_i == `PRI_WRITE_TIMING_ADDR);
   wire hit_sec_wt = (reg_addr_i == `SEC_WRITE_TIMING_ADDR);
   wire hit_pri_mc = (reg_addr_i == `PRI_MISC_CONTROL_ADDR);
   wire hit_sec_mc = (reg_addr_i == `SEC_MISC_CONTROL_ADDR);
   wire acc_chan   = hit_sec_rd | hit_sec_wt | hit_sec_mc;
   wire acc_set    = misc_reg[acc_chan][`SET_SEL_BIT];
   wire [1:0] acc_idx = {acc_chan, acc_set};
   wire wt_read    = reg_access_i & ~reg_write_i & (hit_pri_wt | hit_sec_wt);

   integer i;

   // Register writes and programming-mode detector
   always @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         for (i = 0; i < 4; i = i + 1) begin
            read_timing_reg[i]  <= `TIMING_RESET;
            write_timing_reg[i] <= `TIMING_RESET;
         end
         misc_reg[0]      <= `MISC_RESET;
         misc_reg[1]      <= `MISC_RESET;
         last_wt_read_reg <= 1'b0;
         prog_mode_o      <= 1'b0;
      end else begin
         if (reg_access_i) begin
            // Any other access breaks the double-read sequence
            last_wt_read_reg <= wt_read;
            if (wt_read && last_wt_read_reg)
               prog_mode_o <= 1'b1;
            if (reg_write_i && prog_mode_o) begin
               if (hit_pri_rd | hit_sec_rd)
                  read_timing_reg[acc_idx] <= reg_wdata_i;
               if (hit_pri_wt | hit_sec_wt)
                  write_timing_reg[acc_idx] <= reg_wdata_i;
               if (hit_pri_mc | hit_sec_mc)
                  misc_reg[acc_chan] <= reg_wdata_i;
            end
         end
      end
   end

   // Read data mux
   always @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_access_i && !reg_write_i) begin
         if (hit_pri_rd | hit_sec_rd)
            reg_rdata_o <= read_timing_reg[acc_idx];
         else if (hit_pri_wt | hit_sec_wt)
            reg_rdata_o <= write_timing_reg[acc_idx];
         else if (hit_pri_mc | hit_sec_mc)
            reg_rdata_o <= misc_reg[acc_chan];
         else
            reg_rdata_o <= 8'h00;                               // Unmapped
      end
   end

   // ------------------------------------------------------------
   // Timing decode
   // ------------------------------------------------------------
   wire       cyc_set = misc_reg[cycle_chan_i][`SET_SEL_BIT];
   wire [7:0] tim_sel = cycle_write_i ? write_timing_reg[{cycle_chan_i, cyc_set}]
                                      : read_timing_reg[{cycle_chan_i, cyc_set}];
   wire [2:0] ready_delay_field = misc_reg[cycle_chan_i][`RDLY_MSB:`RDLY_LSB];
   wire [4:0] prog_pulse = {1'b0, tim_sel[`PULSE_MSB:`PULSE_LSB]} + `PULSE_BIAS;
   wire [4:0] prog_recov = {1'b0, tim_sel[`RECOV_MSB:`RECOV_LSB]} + `RECOV_BIAS;
   wire [4:0] prog_rdly  = {2'b00, ready_delay_field} + `RDLY_BIAS;
   wire [4:0] dec_pulse  = cycle_byte_i ? `BYTE_PULSE : prog_pulse;
   wire [4:0] dec_recov  = cycle_byte_i ? `BYTE_RECOV : prog_recov;
   wire [4:0] dec_rdly   = cycle_byte_i ? `BYTE_RDLY  : prog_rdly;

   // ------------------------------------------------------------
   // Strobe sequencer
   // ------------------------------------------------------------
   localparam ST_IDLE  = 2'd0;
   localparam ST_PULSE = 2'd1;
   localparam ST_RECOV = 2'd2;

   reg [1:0] state_reg;
   reg [4:0] pulse_cnt_reg, recov_cnt_reg, rdly_cnt_reg, rdly_len_reg;
   reg       write_reg;
   wire      rdy_ok = rdy_s2_reg && (rdly_cnt_reg >= rdly_len_reg);

   // Pulse, ready wait and recovery timing
   always @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_reg              <= ST_IDLE;
         pulse_cnt_reg          <= 5'h00;
         recov_cnt_reg          <= 5'h00;
         rdly_cnt_reg           <= 5'h00;
         rdly_len_reg           <= 5'h00;
         write_reg              <= 1'b0;
         drive_read_strobe_n_o  <= 1'b1;
         drive_write_strobe_n_o <= 1'b1;
         cycle_busy_o           <= 1'b0;
         cycle_done_o           <= 1'b0;
      end else begin
         cycle_done_o <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               if (cycle_start_i) begin
                  state_reg              <= ST_PULSE;
                  write_reg              <= cycle_write_i;
                  pulse_cnt_reg          <= dec_pulse;
                  recov_cnt_reg          <= dec_recov;
                  rdly_len_reg           <= dec_rdly;
                  rdly_cnt_reg           <= 5'h00;
                  drive_read_strobe_n_o  <= cycle_write_i;
                  drive_write_strobe_n_o <= ~cycle_write_i;
                  cycle_busy_o           <= 1'b1;
               end
            end
            ST_PULSE: begin
               if (pulse_cnt_reg > 5'h01)
                  pulse_cnt_reg <= pulse_cnt_reg - 5'h01;
               // Count clocks since ready seen high; restart if it drops
               if (!rdy_s2_reg)
                  rdly_cnt_reg <= 5'h00;
               else if (rdly_cnt_reg < 5'h1f)
                  rdly_cnt_reg <= rdly_cnt_reg + 5'h01;
               if (pulse_cnt_reg <= 5'h01 && rdy_ok) begin
                  state_reg              <= ST_RECOV;
                  drive_read_strobe_n_o  <= 1'b1;
                  drive_write_strobe_n_o <= 1'b1;
               end
            end
            ST_RECOV: begin
               if (recov_cnt_reg > 5'h01) begin
                  recov_cnt_reg <= recov_cnt_reg - 5'h01;
               end else begin
                  state_reg    <= ST_IDLE;
                  cycle_busy_o <= 1'b0;
                  cycle_done_o <= 1'b1;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

endmodule // drive_cycle_timing_encoder
`default_nettype wire

//--- sim/drive_cycle_timing_encoder_props.sv
/* Assertions on the drive cycle timing encoder ports.
   Assumes it is bound onto every encoder instance. */
`timescale 1ns/10ps
`default_nettype none
`include "drive_timing_defines.vh"
module drive_cycle_timing_encoder_props (
   input wire logic       core_clk_i,
   input wire logic       rst_n_i,
   input wire logic       reg_access_i,
   input wire logic       reg_write_i,
   input wire logic       cycle_start_i,
   input wire logic       cycle_write_i,
   input wire logic       prog_mode_o,
   input wire logic       cycle_busy_o,
   input wire logic       cycle_done_o,
   input wire logic       drive_read_strobe_n_o,
   input wire logic       drive_write_strobe_n_o,
   input wire logic [9:0] reg_addr_i
);
   // ------------
   // Properties
   // ------------
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   // Read of either write timing address, and both strobes idle
   wire pr_rd = reg_access_i && !reg_write_i &&
      (reg_addr_i == `PRI_WRITE_TIMING_ADDR || reg_addr_i == `SEC_WRITE_TIMING_ADDR);
   wire idle = drive_read_strobe_n_o && drive_write_strobe_n_o;
   property p_prog_enter; pr_rd ##1 pr_rd |=> prog_mode_o; endproperty
   a_prog_enter: assert property (p_prog_enter) else $error("no program mode");
   property p_prog_stay; prog_mode_o |=> prog_mode_o; endproperty
   a_prog_stay: assert property (p_prog_stay) else $error("program mode lost");
   property p_start; cycle_start_i && !cycle_busy_o && !cycle_done_o |=> cycle_busy_o &&
      (drive_write_strobe_n_o == !$past(cycle_write_i)) && (drive_read_strobe_n_o == $past(cycle_write_i)); endproperty
   a_start: assert property (p_start) else $error("wrong strobe at start");
   property p_excl; !(!drive_read_strobe_n_o && !drive_write_strobe_n_o); endproperty
   a_excl: assert property (p_excl) else $error("both strobes low");
   property p_recov; $rose(idle) |-> idle[*2]; endproperty
   a_recov: assert property (p_recov) else $error("recovery too short");
   property p_done_one; cycle_done_o |=> !cycle_done_o; endproperty
   a_done_one: assert property (p_done_one) else $error("done too long");
   property p_done_idle; cycle_done_o |-> !cycle_busy_o && idle; endproperty
   a_done_idle: assert property (p_done_idle) else $error("done while active");
   property p_strobe_busy; !idle |-> cycle_busy_o; endproperty
   a_strobe_busy: assert property (p_strobe_busy) else $error("strobe without busy");
endmodule // drive_cycle_timing_encoder_props
bind drive_cycle_timing_encoder drive_cycle_timing_encoder_props
   drive_cycle_timing_encoder_props_inst (.core_clk_i,
   .rst_n_i, .reg_access_i, .reg_write_i, .cycle_start_i, .cycle_write_i, .prog_mode_o,
   .cycle_busy_o, .cycle_done_o, .drive_read_strobe_n_o, .drive_write_strobe_n_o, .reg_addr_i);
`default_nettype wire

//--- sim/drive_model.sv
/* Drive on the cable: stretches a strobe by holding ready low.
   Assumes the pin has a pull-up, so it idles high. */
`timescale 1ns/10ps
`default_nettype none
module drive_model (
   input wire logic       clk_i,
   input wire logic       rd_n_i,
   input wire logic       wr_n_i,
   input wire logic [3:0] wait_i,   // Cycles of stretch, zero answers at once
   output var logic       ready_o
);
   int cnt = 0;
   initial ready_o = 1'b1;
   // Ready low for wait_i cycles after a strobe falls, pulled high otherwise
   always @(posedge clk_i) begin
      cnt <= (rd_n_i && wr_n_i) ? 0 : cnt + 1;
      ready_o <= (rd_n_i && wr_n_i) || (cnt >= wait_i);
   end
endmodule // drive_model
`default_nettype wire

//--- sim/test_drive_cycle_timing_encoder.sv
/* Self-checking bench for the drive cycle timing encoder.
   Assumes the encoder, its props binding and the drive model. */
`timescale 1ns/10ps
`default_nettype none
`include "drive_timing_defines.vh"
module test_drive_cycle_timing_encoder;
   logic       core_clk_i = 0, rst_n_i = 0, reg_access_i = 0, reg_write_i = 0, ready;
   logic       cycle_start_i = 0, cycle_write_i = 0, cycle_chan_i = 0, cycle_byte_i = 0;
   logic       prog_mode_o, rd_n, wr_n, busy, done;
   logic [9:0] reg_addr_i = 0;
   logic [7:0] reg_wdata_i = 0, reg_rdata_o, rd_v, d;
   logic [3:0] ready_wait = 0;
   logic [7:0] mdl_t [0:1][0:1][0:1];   // Timing copies by channel, direction, set
   logic [7:0] mdl_misc [0:1];
   int         fails = 0, compares = 0, lo, hi, rdy, ep, er, ed;
   // ------------
   // Clock, design and drive
   // ------------
   always #10 core_clk_i = ~core_clk_i;
   drive_cycle_timing_encoder drive_cycle_timing_encoder_inst (.core_clk_i, .rst_n_i,
      .reg_access_i, .reg_write_i, .reg_addr_i, .reg_wdata_i, .cycle_start_i, .cycle_write_i,
      .cycle_chan_i, .cycle_byte_i, .drive_io_ready_n_i(ready), .reg_rdata_o, .prog_mode_o,
      .drive_read_strobe_n_o(rd_n), .drive_write_strobe_n_o(wr_n), .cycle_busy_o(busy),
      .cycle_done_o(done));
   drive_model drive_model_inst (.clk_i(core_clk_i), .rd_n_i(rd_n), .wr_n_i(wr_n),
      .wait_i(ready_wait), .ready_o(ready));
   // Compare and count
   task check(input logic [7:0] seen, exp, input string msg);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask
   // One register access, read data captured after it lands
   task acc(input logic w, input logic [9:0] a, input logic [7:0] dt);
      @(negedge core_clk_i); reg_access_i = 1; reg_write_i = w; reg_addr_i = a; reg_wdata_i = dt;
      @(negedge core_clk_i); reg_access_i = 0;
      @(posedge core_clk_i); #1 rd_v = reg_rdata_o;
   endtask
   task wr(input int ch, k, input logic [7:0] dt);
      if (k == 6) mdl_misc[ch] = dt; else mdl_t[ch][k][mdl_misc[ch][0]] = dt;
      acc(1, (ch ? `SEC_READ_TIMING_ADDR : `PRI_READ_TIMING_ADDR) + 10'(k), dt);
   endtask
   task rd(input int ch, k);
      acc(0, (ch ? `SEC_READ_TIMING_ADDR : `PRI_READ_TIMING_ADDR) + 10'(k), 8'h00);
      check(rd_v, k == 6 ? mdl_misc[ch] : mdl_t[ch][k][mdl_misc[ch][0]], "readback");
   endtask
   // One drive cycle, strobe width, ready time and recovery measured
   task cyc(input int ch, w, b);
      d = mdl_t[ch][w][mdl_misc[ch][0]];
      ep = b ? `BYTE_PULSE : d[7:4] + 1;
      er = b ? `BYTE_RECOV : d[3:0] + 2;
      ed = b ? `BYTE_RDLY : mdl_misc[ch][3:1] + 2;
      @(negedge core_clk_i); cycle_start_i = 1; cycle_chan_i = ch[0]; cycle_write_i = w[0];
      cycle_byte_i = b[0]; ready_wait = 4'($urandom_range(0, 12));
      @(negedge core_clk_i); cycle_start_i = 0; lo = 0; hi = 0; rdy = 0;
      while ((w ? wr_n : rd_n) === 1'b0 && lo < 100) begin
         lo++; rdy += ready; @(negedge core_clk_i);
      end
      while (done !== 1'b1 && hi < 100) begin
         hi++; @(negedge core_clk_i);
      end
      check(lo >= ep, 1, "pulse short");
      check(rdy >= ed, 1, "ready delay short");
      check(hi >= er, 1, "recovery short");
      check(busy, 0, "busy after done");
      if (ready_wait == 0 && ep > ed) check(8'(lo), 8'(ep), "pulse width");
   endtask
   task complete_run;
      $display("counts: %0d compares, %0d fails", compares, fails);
      if (fails == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // ------------
   // Tests
   // ------------
   initial begin
      void'($urandom(9050));
      mdl_t = '{default: 8'h00};
      mdl_misc = '{default: 8'h00};
      repeat (12) @(posedge core_clk_i);
      @(negedge core_clk_i) rst_n_i = 1;
      repeat (3) @(posedge core_clk_i);
      acc(1, `PRI_READ_TIMING_ADDR, 8'h5a);
      for (int ch = 0; ch < 2; ch++) for (int k = 0; k < 7; k += (k == 1) ? 5 : 1) rd(ch, k);
      acc(0, 10'h1f2, 8'h00);
      check(rd_v, 8'h00, "unmapped read");
      check(prog_mode_o, 8'h00, "early program mode");
      $display("test reset and refusal done");
      @(negedge core_clk_i); reg_access_i = 1; reg_write_i = 0;
      reg_addr_i = `PRI_WRITE_TIMING_ADDR;
      repeat (2) @(negedge core_clk_i);
      reg_access_i = 0;
      @(posedge core_clk_i); #1 check(prog_mode_o, 1, "program mode");
      $display("test program mode done");
      for (int ch = 0; ch < 2; ch++) for (int s = 0; s < 2; s++) begin
         wr(ch, 6, 8'($urandom_range(0, 127)) & 8'hfe | 8'(s));
         wr(ch, 0, 8'($urandom));
         wr(ch, 1, 8'($urandom));
      end
      for (int ch = 0; ch < 2; ch++) for (int s = 0; s < 2; s++) begin
         wr(ch, 6, 8'($urandom_range(0, 127)) & 8'hfe | 8'(s));
         rd(ch, 0); rd(ch, 1); rd(ch, 6);
      end
      $display("test register sets done");
      for (int i = 0; i < 24; i++) begin
         wr(i % 2, 6, 8'($urandom));
         wr(i % 2, (i / 2) % 2, (i < 4) ? 8'h00 : (i < 8) ? 8'hff : 8'($urandom));
         cyc(i % 2, (i / 2) % 2, i % 5 == 4);
      end
      $display("test drive cycles done");
      complete_run;
   end
   // Watchdog well beyond the expected run of some 20 us
   initial begin
      #400us;
      fails++;
      complete_run;
   end
endmodule // test_drive_cycle_timing_encoder
`default_nettype wire
